// file: core/fet_drive_pkg.sv
// Package: constants and types for the protection FET driver control
package fet_drive_pkg;
  localparam int CLK_MHZ = 100;
  // Active pull-low time of the charge driver after turn-off
  localparam int CHG_PULL_US = 100;
  localparam int CHG_PULL_CYC = CHG_PULL_US * CLK_MHZ;
  // Current result width (signed, positive = charging)
  localparam int CUR_W = 16;
  localparam int PWM_W = 16;
  // Fault vector bit positions for the discharge path
  localparam int DF_LOWV = 0;
  localparam int DF_HOT = 1;
  localparam int DF_COLD = 2;
  localparam int DF_OC1 = 3;
  localparam int DF_OC2 = 4;
  localparam int DF_SHORT = 5;
  localparam int DF_DIAG = 6;
  localparam int DF_N = 7;
  // Fault vector bit positions for the charge path
  localparam int CF_HIGHV = 0;
  localparam int CF_HOT = 1;
  localparam int CF_COLD = 2;
  localparam int CF_OC = 3;
  localparam int CF_SHORT = 4;
  localparam int CF_DIAG = 5;
  localparam int CF_N = 6;
  // Charge pin drive states
  typedef enum logic [2:0] {
    CHG_FLOAT = 3'b001,
    CHG_HIGH = 3'b010,
    CHG_PULL = 3'b100
  } chg_state_t;
endpackage : fet_drive_pkg

// file: core/fet_drive_ctrl.sv
// Protection FET driver control: gate decisions, body diode, PWM, detector gating
// Summary of operation
// R1 - Discharge gate high only if unblocked and no enabled discharge fault, or permitted force, or body diode
// R2 - Charge gate high only if unblocked and no enabled charge fault, or permitted force, or body diode
// R3 - Force-on commands honoured only when configuration permits forcing that driver
// R4 - Configuration masks choose which faults autonomously turn off each driver
// R5 - Discharge off disables both discharge overcurrent and short detectors
// R6 - Charge driver state never affects overcurrent detector enables
// R7 - Charge driver pulls low 100 us on disable, then floats
// R8 - Body diode protection only in series mode with one driver on, other off
// R9 - Discharge driver may turn on during its fault when pack is charging
// R10 - Charge driver may turn on during its fault when pack is discharging
// R11 - Charging or discharging recognised only above a programmable absolute threshold
// R12 - Positive current means charging; range covers plus or minus 200 mV
// R13 - PWM mode switches both drivers to limit average current
// R14 - Discharge PWM drives both levels; charge PWM only with no charger
// R15 - Filtered currents and charge integration are read elsewhere, not here
// R16 - Block bits keep a driver off until cleared, regardless of faults
// R17 - PWM period and on-time configured; suppressed while blocked or faulted
module fet_drive_ctrl
  import fet_drive_pkg::*;
#(
  parameter int CHG_PULL_CYCLES = CHG_PULL_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host commands
  input wire logic dsg_block,
  input wire logic chg_block,
  input wire logic dsg_force,
  input wire logic chg_force,
  // Configuration
  input wire logic dsg_force_allow,
  input wire logic chg_force_allow,
  input wire logic [DF_N-1:0] dsg_fault_mask,
  input wire logic [CF_N-1:0] chg_fault_mask,
  input wire logic series_mode,
  input wire logic body_diode_en,
  input wire logic [CUR_W-1:0] body_diode_thresh,
  input wire logic dsg_pwm_en,
  input wire logic chg_pwm_en,
  input wire logic [PWM_W-1:0] pwm_period,
  input wire logic [PWM_W-1:0] dsg_pwm_on,
  input wire logic [PWM_W-1:0] chg_pwm_on,
  input wire logic charger_present,
  // Fault and measurement inputs (same clock domain)
  input wire logic [DF_N-1:0] dsg_faults,
  input wire logic [CF_N-1:0] chg_faults,
  input wire logic signed [CUR_W-1:0] cc_current, // R12 R15
  // Driver pins: output enable low while driving
  output logic discharge_fet_drive,
  output logic charge_fet_drive,
  output logic charge_fet_drive_oe_n,
  // Detector enables and status
  output logic ocd_detect_en,
  output logic scd_detect_en,
  output logic dsg_on,
  output logic chg_on
);

  logic [PWM_W-1:0] pwm_cnt_q, pwm_cnt_d;
  logic dsg_q, dsg_d, chg_q, chg_d;
  chg_state_t cst_q, cst_d;
  // Pull-low counter width and end value, sized from the parameter
  localparam int PULL_W = $clog2(CHG_PULL_CYCLES + 1);
  localparam logic [PULL_W-1:0] PULL_LAST = PULL_W'(CHG_PULL_CYCLES - 1);
  localparam logic [PULL_W:0] RUN_MAX = (PULL_W + 1)'(CHG_PULL_CYCLES);
  logic [PULL_W-1:0] pull_q, pull_d;
  logic [PULL_W:0] low_run_q, low_run_d;
  logic dsg_fault_act, chg_fault_act, is_chg, is_dsg, dsg_base, chg_base;
  logic dsg_want, chg_want, dsg_bd, chg_bd;
  logic [CUR_W-1:0] cur_abs;

  // Any fault that is present and allowed to act autonomously on a driver
  function automatic logic fault_active(input logic [7:0] faults, input logic [7:0] mask);
    return |(faults & mask);
  endfunction : fault_active

  // Decision logic
  always_comb begin
    // Masks are widened on purpose so one decoder serves both drivers
    dsg_fault_act = fault_active(8'(dsg_faults), 8'(dsg_fault_mask)); // R4
    chg_fault_act = fault_active(8'(chg_faults), 8'(chg_fault_mask)); // R4
    // Positive sense means charging; magnitude against threshold
    cur_abs = cc_current[CUR_W-1] ? CUR_W'(-cc_current) : cc_current; // R12
    is_chg = !cc_current[CUR_W-1] && (cur_abs > body_diode_thresh); // R11
    is_dsg = cc_current[CUR_W-1] && (cur_abs > body_diode_thresh); // R11
    dsg_base = (!dsg_fault_act || (dsg_force && dsg_force_allow)); // R3
    chg_base = (!chg_fault_act || (chg_force && chg_force_allow)); // R3
    // Body diode only in series mode with exactly one driver already on
    dsg_bd = body_diode_en && series_mode && chg_q && !dsg_q && is_chg; // R8 R9
    chg_bd = body_diode_en && series_mode && dsg_q && !chg_q && is_dsg; // R8 R10
    // Block always wins, even over body diode, so host can hold FETs off
    dsg_want = !dsg_block && (dsg_base || dsg_bd || (dsg_q && dsg_fault_act && !dsg_base
               && body_diode_en && series_mode && is_chg)); // R1 R16
    chg_want = !chg_block && (chg_base || chg_bd || (chg_q && chg_fault_act && !chg_base
               && body_diode_en && series_mode && is_dsg)); // R2 R16
    pwm_cnt_d = (pwm_cnt_q + 1'b1 >= pwm_period) ? '0 : PWM_W'(pwm_cnt_q + 1'b1); // R17
    // PWM only modulates an already permitted driver
    dsg_d = dsg_want && (!dsg_pwm_en || pwm_cnt_q < dsg_pwm_on); // R13 R14 R17
    chg_d = chg_want && (!chg_pwm_en || charger_present || pwm_cnt_q < chg_pwm_on); // R13 R14 R17
  end

  // Decision registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_cnt_q <= '0;
      dsg_q <= 1'b0;
      chg_q <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_d;
      dsg_q <= dsg_d;
      chg_q <= chg_d;
    end
  end

  // Charge pin: drive high, pull low for a fixed time, then release
  always_comb begin
    cst_d = cst_q;
    pull_d = pull_q;
    unique case (cst_q)
      CHG_FLOAT: if (chg_q) cst_d = CHG_HIGH;
      CHG_HIGH: if (!chg_q) begin
        cst_d = CHG_PULL;
        pull_d = '0;
      end
      CHG_PULL: begin
        if (chg_q) cst_d = CHG_HIGH;
        else if (pull_q == PULL_LAST) cst_d = CHG_FLOAT; // R7
        else pull_d = pull_q + 1'b1;
      end
      default: cst_d = CHG_FLOAT;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cst_q <= CHG_FLOAT;
      pull_q <= '0;
    end else begin
      cst_q <= cst_d;
      pull_q <= pull_d;
    end
  end

  // Outputs straight from flip-flops; one cycle behind the decisions
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      discharge_fet_drive <= 1'b0;
      charge_fet_drive <= 1'b0;
      charge_fet_drive_oe_n <= 1'b1;
      ocd_detect_en <= 1'b0;
      scd_detect_en <= 1'b0;
      dsg_on <= 1'b0;
      chg_on <= 1'b0;
    end else begin
      discharge_fet_drive <= dsg_q; // R1 R14
      charge_fet_drive <= (cst_d == CHG_HIGH); // R7
      charge_fet_drive_oe_n <= (cst_d == CHG_FLOAT); // R7
      ocd_detect_en <= dsg_q; // R5 R6
      scd_detect_en <= dsg_q; // R5 R6
      dsg_on <= dsg_q;
      chg_on <= chg_q;
    end
  end

  // Helper: length of the running pull-low phase on the charge pin, saturating
  always_comb begin
    low_run_d = low_run_q;
    if (charge_fet_drive_oe_n || charge_fet_drive) begin
      low_run_d = '0;
    end else if (low_run_q <= RUN_MAX) begin
      low_run_d = low_run_q + 1'b1;
    end
  end

  // Helper register; a long pull would stress the gate, so its length is watched
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_run_q <= '0;
    end else begin
      low_run_q <= low_run_d;
    end
  end

  // Body diode entry conditions, one per driver
  sequence dsg_diode_s;
    body_diode_en && series_mode && chg_q && !dsg_q && is_chg && !dsg_block && !dsg_pwm_en;
  endsequence
  sequence chg_diode_s;
    body_diode_en && series_mode && dsg_q && !chg_q && is_dsg && !chg_block && !chg_pwm_en;
  endsequence
  // Charge pin going from high drive to low
  sequence chg_drop_s;
    charge_fet_drive ##1 !charge_fet_drive;
  endsequence

  // Block reaches the discharge pin two edges later
  block_dsg_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
    dsg_block |-> ##2 !discharge_fet_drive)
    else $error("dsg on while blocked");
  // Block clears the charge decision at the next edge
  block_chg_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
    chg_block |-> ##1 !chg_q)
    else $error("chg on while blocked");
  // Block clears the discharge decision at the next edge
  block_dsg_q_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
    dsg_block |-> ##1 !dsg_q)
    else $error("dsg decision on while blocked");
  // Active discharge fault keeps the driver off unless forced or diode rescue may apply
  dsg_fault_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
    (dsg_fault_act && !(dsg_force && dsg_force_allow) && !(body_diode_en && series_mode))
    |-> ##1 !dsg_q)
    else $error("dsg on during fault");
  // Same for the charge driver
  chg_fault_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
    (chg_fault_act && !(chg_force && chg_force_allow) && !(body_diode_en && series_mode))
    |-> ##1 !chg_q)
    else $error("chg on during fault");
  // Discharge pin lags its decision by exactly one edge
  dsg_pin_lag_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
    discharge_fet_drive == $past(dsg_q))
    else $error("dsg pin does not follow decision");
  // Status bits track the decisions with the pin timing
  dsg_status_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
    dsg_on == discharge_fet_drive)
    else $error("dsg status mismatch");
  chg_status_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
    chg_on == $past(chg_q))
    else $error("chg status mismatch");
  // A permitted force turns the driver on even during a fault
  force_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
    (!dsg_block && !dsg_pwm_en && dsg_force && dsg_force_allow) |-> ##1 dsg_q)
    else $error("allowed force ignored");
  // Detectors run only while the discharge pin is high
  detect_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
    ocd_detect_en == discharge_fet_drive && scd_detect_en == discharge_fet_drive)
    else $error("detector enable mismatch");
  // Charge driver off must not stop the detectors
  detect_free_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
    (!chg_q && dsg_q) |-> ##1 (ocd_detect_en && scd_detect_en))
    else $error("detectors follow charge driver");
  // A fall from high drive is an active pull, not a release
  pull_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    (chg_drop_s and ##1 (cst_q == CHG_PULL)) |-> !charge_fet_drive_oe_n)
    else $error("charge pin not pulled low");
  // The last pull count releases the pin
  pull_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    (cst_q == CHG_PULL && !chg_q && pull_q == PULL_LAST) |-> ##1 charge_fet_drive_oe_n)
    else $error("charge pin not released");
  // The pull phase never outlasts its set time
  pull_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    low_run_q <= RUN_MAX)
    else $error("charge pull too long");
  // After the full pull the pin is released or driven high again
  pull_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    (low_run_q == RUN_MAX) |-> (charge_fet_drive_oe_n || charge_fet_drive))
    else $error("charge pull not ended");
  // High drive always has the output enabled; a released pin shows low
  drive_enable_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    charge_fet_drive |-> !charge_fet_drive_oe_n)
    else $error("charge high while released");
  float_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    charge_fet_drive_oe_n |-> !charge_fet_drive)
    else $error("released charge pin shows high");
  // A new charge decision drives the pin high one edge later
  chg_rise_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    $rose(chg_q) |-> ##1 charge_fet_drive)
    else $error("charge pin not driven high");
  // Outside series mode no diode rescue
  diode_series_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
    (!series_mode && dsg_fault_act && !(dsg_force && dsg_force_allow)) |-> ##1 !dsg_q)
    else $error("body diode outside series mode");
  // Diode rescue turns the off driver on
  diode_dsg_on_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
    dsg_diode_s |-> ##1 dsg_q)
    else $error("dsg diode rescue missing");
  diode_chg_on_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R10
    chg_diode_s |-> ##1 chg_q)
    else $error("chg diode rescue missing");
  // Without current beyond the threshold a faulted driver stays off
  diode_dsg_thr_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
    (dsg_fault_act && !(dsg_force && dsg_force_allow) && !is_chg) |-> ##1 !dsg_q)
    else $error("dsg rescue below threshold");
  diode_chg_thr_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
    (chg_fault_act && !(chg_force && chg_force_allow) && !is_dsg) |-> ##1 !chg_q)
    else $error("chg rescue below threshold");
  // Discharge off phase of the PWM
  pwm_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R13
    (dsg_pwm_en && pwm_cnt_q >= dsg_pwm_on) |-> ##1 !dsg_q)
    else $error("pwm off phase ignored");
  // Charge PWM switches only with no charger
  chg_pwm_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
    (chg_pwm_en && !charger_present && pwm_cnt_q >= chg_pwm_on) |-> ##1 !chg_q)
    else $error("charge pwm off phase ignored");
  charger_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
    (chg_want && charger_present) |-> ##1 chg_q)
    else $error("charge switched with charger");
  // A period of zero or one keeps the counter at zero
  pwm_short_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R17
    (pwm_period <= 16'h0001) |-> ##1 (pwm_cnt_q == '0))
    else $error("pwm counter runs on short period");

endmodule : fet_drive_ctrl

// file: testbench/fet_pair_model.sv
// Model of the external charge and discharge NFET gates
module fet_pair_model (
  // Gate drive from the device
  input wire logic dsg_drive,
  input wire logic chg_drive,
  input wire logic chg_oe_n,
  // Resolved gate levels
  output logic dsg_gate,
  output logic chg_gate
);
  // Gate-source resistor takes a released gate to pack negative, never to its last level
  assign chg_gate = chg_oe_n ? 1'b0 : chg_drive;
  assign dsg_gate = dsg_drive;
endmodule : fet_pair_model

// file: testbench/tb.sv
// Self-checking testbench for the protection FET driver control
module tb import fet_drive_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic dsg_block = 1'b0, chg_block = 1'b0, dsg_force = 1'b0, chg_force = 1'b0;
  logic dsg_force_allow = 1'b0, chg_force_allow = 1'b0, series_mode = 1'b0;
  logic body_diode_en = 1'b0, dsg_pwm_en = 1'b0, chg_pwm_en = 1'b0, charger_present = 1'b0;
  logic [DF_N-1:0] dsg_fault_mask = '1, dsg_faults = '0;
  logic [CF_N-1:0] chg_fault_mask = '1, chg_faults = '0;
  logic [CUR_W-1:0] body_diode_thresh = 16'h0064;
  logic signed [CUR_W-1:0] cc_current = 16'sh0000;
  logic [PWM_W-1:0] pwm_period = 16'h0004, dsg_pwm_on = 16'h0002, chg_pwm_on = 16'h0002;
  logic discharge_fet_drive, charge_fet_drive, charge_fet_drive_oe_n;
  logic ocd_detect_en, scd_detect_en, dsg_on, chg_on, dsg_gate, chg_gate;
  int errors = 0, samples_checked = 0;
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // Short pull-low count keeps the run brief
  fet_drive_ctrl #(.CHG_PULL_CYCLES(8)) fet_drive_ctrl_inst (.sys_clk, .sys_rst, .dsg_block,
    .chg_block, .dsg_force, .chg_force, .dsg_force_allow, .chg_force_allow, .dsg_fault_mask,
    .chg_fault_mask, .series_mode, .body_diode_en, .body_diode_thresh, .dsg_pwm_en,
    .chg_pwm_en, .pwm_period, .dsg_pwm_on, .chg_pwm_on, .charger_present, .dsg_faults,
    .chg_faults, .cc_current, .discharge_fet_drive, .charge_fet_drive, .charge_fet_drive_oe_n,
    .ocd_detect_en, .scd_detect_en, .dsg_on, .chg_on);
  fet_pair_model fet_pair_model_inst (.dsg_drive(discharge_fet_drive),
    .chg_drive(charge_fet_drive), .chg_oe_n(charge_fet_drive_oe_n), .dsg_gate, .chg_gate);
  // Inputs move 1 ns after the edge so no race with the design
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  // Compare one level
  task automatic chk(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  // Pins settle two edges after inputs; four leaves margin
  task automatic expect_fets(input logic d, input logic c);
    step(4);
    chk("dsg_gate", d, dsg_gate);
    chk("ocd_detect_en", d, ocd_detect_en);
    chk("scd_detect_en", d, scd_detect_en);
    chk("chg_gate", c, chg_gate);
    chk("dsg_on", d, dsg_on);
    chk("chg_on", c, chg_on);
  endtask : expect_fets
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // Each fault bit acts only when its mask bit allows it
  task automatic fault_masks();
    for (int b = 0; b < DF_N; b++) begin
      dsg_faults = '0;
      dsg_faults[b] = 1'b1;
      dsg_fault_mask = ~dsg_faults;
      expect_fets(1'b1, 1'b1);
      dsg_fault_mask = '1;
      expect_fets(1'b0, 1'b1);
    end
    dsg_faults = '0;
    for (int b = 0; b < CF_N; b++) begin
      chg_faults = '0;
      chg_faults[b] = 1'b1;
      chg_fault_mask = ~chg_faults;
      expect_fets(1'b1, 1'b1);
      chg_fault_mask = '1;
      expect_fets(1'b1, 1'b0);
    end
  endtask : fault_masks
  // Force needs its allow bit; block beats force
  task automatic force_block();
    dsg_force = 1'b1;
    chg_force = 1'b1;
    dsg_faults = 7'h01;
    chg_faults = 6'h01;
    expect_fets(1'b0, 1'b0);
    dsg_force_allow = 1'b1;
    chg_force_allow = 1'b1;
    expect_fets(1'b1, 1'b1);
    dsg_block = 1'b1;
    chg_block = 1'b1;
    expect_fets(1'b0, 1'b0);
    {dsg_force, chg_force, dsg_block, dsg_faults, chg_faults} = '0;
    expect_fets(1'b1, 1'b0);
    chg_block = 1'b0;
    expect_fets(1'b1, 1'b1);
  endtask : force_block
  // Charge pin pulls low for the set count, then floats
  task automatic chg_release();
    chg_block = 1'b1;
    step(3);
    chk("chg_oe_n", 1'b0, charge_fet_drive_oe_n);
    chk("charge_fet_drive", 1'b0, charge_fet_drive);
    step(5);
    chk("chg_oe_n", 1'b0, charge_fet_drive_oe_n);
    step(5);
    chk("chg_oe_n", 1'b1, charge_fet_drive_oe_n);
    chg_block = 1'b0;
  endtask : chg_release
  // Body diode: strictly above threshold, series only
  task automatic body_diode();
    series_mode = 1'b1;
    body_diode_en = 1'b1;
    dsg_faults = 7'h01;
    cc_current = 16'sh0065;
    expect_fets(1'b1, 1'b1);
    cc_current = 16'sh0064;
    expect_fets(1'b0, 1'b1);
    cc_current = 16'sh0065;
    expect_fets(1'b1, 1'b1);
    dsg_faults = '0;
    chg_faults = 6'h01;
    cc_current = -16'sh0065;
    expect_fets(1'b1, 1'b1);
    series_mode = 1'b0;
    expect_fets(1'b1, 1'b0);
    chg_faults = '0;
  endtask : body_diode
  // Reset in mid-run drops the discharge gate, overcurrent enable and charge output enable to idle, then recovers
  task automatic reset_mid();
    sys_rst = 1'b1;
    step(2);
    chk("dsg_gate", 1'b0, dsg_gate);
    chk("ocd_detect_en", 1'b0, ocd_detect_en);
    chk("chg_oe_n", 1'b1, charge_fet_drive_oe_n);
    sys_rst = 1'b0;
    expect_fets(1'b1, 1'b1);
  endtask : reset_mid
  // PWM halves discharge on-time; charger holds charge on; faults stop switching
  task automatic pwm_run();
    int highs = 0;
    int chg_highs = 0;
    {dsg_pwm_en, chg_pwm_en, charger_present} = 3'h7;
    step(4);
    repeat (8) begin
      highs += int'(discharge_fet_drive);
      chk("chg_gate", 1'b1, chg_gate);
      step(1);
    end
    chk("dsg_pwm_half", 1'b1, highs == 4);
    dsg_faults = 7'h02;
    expect_fets(1'b0, 1'b1);
    charger_present = 1'b0;
    step(4);
    repeat (8) begin
      chg_highs += int'(chg_gate);
      step(1);
    end
    chk("chg_pwm_half", 1'b1, chg_highs == 4);
  endtask : pwm_run
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #20us;
    errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    step(8);
    sys_rst = 1'b0;
    expect_fets(1'b1, 1'b1);
    fault_masks();
    force_block();
    chg_release();
    body_diode();
    reset_mid();
    pwm_run();
    tally_and_finish();
  end
endmodule : tb
